//--- hw/tcp_defs.svh
// Constants for the capture/compare pair: offsets, fields, reset values
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH
`define TCP_OFF_MODE 12'h000
`define TCP_OFF_CCCTL 12'h004
`define TCP_OFF_EDGE 12'h008
`define TCP_OFF_REGA 12'h00C
`define TCP_OFF_REGB 12'h010
`define TCP_OFF_COUNT 12'h014
`define TCP_OFF_STAT 12'h018
`define TCP_MODE_RST 8'h00
`define TCP_REG_RST 16'h0000
`define TCP_CNT_ZERO 16'h0000
`define TCP_CNT_ONE 16'h0001
`define TCP_CNT_MAX 16'hFFFF
`define TCP_OPM_STOP 2'h0
`define TCP_OPM_FREE 2'h1
`define TCP_OPM_EDGE 2'h2
`define TCP_OPM_MATCH 2'h3
`define TCP_ES_FALL 2'h0
`define TCP_ES_RISE 2'h1
`define TCP_ES_BOTH 2'h3
`define TCP_ES_BAD 2'h2
`define TCP_MODE_OPM_LSB 2
`define TCP_MODE_OVF_BIT 0
`define TCP_CC_A_CAP 0
`define TCP_CC_A_SRC 1
`define TCP_CC_B_CAP 2
`define TCP_CC_PPG 3
`endif

//--- hw/tcp_pkg.sv
// Types shared by the capture/compare pair
`default_nettype none
package tcp_pkg;
  typedef struct packed {
    logic rise;
    logic fall;
  } tcp_edges_t;
  typedef struct packed {
    logic [1:0] sel_b;
    logic [1:0] sel_a;
  } tcp_edge_cfg_t;
endpackage
`default_nettype wire

//--- hw/tcp_edge_det.sv
// Two-flop synchroniser and edge detector for one trigger pin
`default_nettype none
module tcp_edge_det (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output tcp_pkg::tcp_edges_t edges
);
  logic sync1;
  logic sync2;
  logic prev;
  // Synchroniser stages, then a history flop for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      prev <= sync2;
    end
  end
  // Edges are seen only on the second stage and its history
  assign edges.rise = sync2 & ~prev;
  assign edges.fall = ~sync2 & prev;
endmodule
`default_nettype wire

//--- hw/tcp_capcmp.sv
// One capture/compare register with capture load and match detect
`default_nettype none
`include "tcp_defs.svh"
module tcp_capcmp (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic cap_en,
  input wire logic [15:0] count,
  output logic [15:0] value,
  output logic match
);
  // Capture has priority over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= `TCP_REG_RST;
    end else if (cap_en) begin
      value <= count;
    end else if (wr_en) begin
      value <= wr_data;
    end
  end
  // Equality against the running count
  assign match = (value == count);
endmodule
`default_nettype wire

//--- hw/tcp_top.sv
// Timer channel: up-counter, capture/compare pair and APB register file
`default_nettype none
`include "tcp_defs.svh"
module tcp_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_pin_a,
  input wire logic trigger_pin_b,
  output logic match_irq_a,
  output logic match_irq_b
);
  typedef enum logic [0:0] {TCP_IDLE, TCP_RUN} tcp_state_t;

  logic [7:0] timer_mode_control;
  logic [3:0] capcmp_control;
  tcp_pkg::tcp_edge_cfg_t edge_cfg;
  logic [15:0] up_counter;
  logic [15:0] capcmp_reg_a;
  logic [15:0] capcmp_reg_b;
  logic match_a;
  logic match_b;
  logic ovf;
  logic irq_a_q;
  logic irq_b_q;
  tcp_state_t state;
  tcp_state_t next_state;
  tcp_pkg::tcp_edges_t edges_a;
  tcp_pkg::tcp_edges_t edges_b;

  // Edge-selected trigger decode, shared by several capture paths
  function automatic logic edge_hit(input logic [1:0] sel, input tcp_pkg::tcp_edges_t e);
    case (sel)
      `TCP_ES_FALL: edge_hit = e.fall;
      `TCP_ES_RISE: edge_hit = e.rise;
      `TCP_ES_BOTH: edge_hit = e.rise | e.fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // Trigger pin synchronisers
  tcp_edge_det u_det_a (
    .pclk(pclk),
    .presetn(presetn),
    .pin(trigger_pin_a),
    .edges(edges_a)
  );
  tcp_edge_det u_det_b (
    .pclk(pclk),
    .presetn(presetn),
    .pin(trigger_pin_b),
    .edges(edges_b)
  );

  // Mode fields and bus decode
  wire [1:0] op_mode = timer_mode_control[`TCP_MODE_OPM_LSB +: 2];
  wire op_mode_hi = op_mode[1];
  wire op_mode_lo = op_mode[0];
  // Writing the stop code halts the channel at once, not one edge later
  wire running = (state == TCP_RUN) & (op_mode != `TCP_OPM_STOP);
  wire reg_a_capture_select = capcmp_control[`TCP_CC_A_CAP];
  wire reg_a_src_b = capcmp_control[`TCP_CC_A_SRC];
  wire reg_b_capture_select = capcmp_control[`TCP_CC_B_CAP];
  wire ppg_mode = capcmp_control[`TCP_CC_PPG];
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire word_wr = wr & (pstrb == 4'hF);
  wire hit_mode = (paddr == `TCP_OFF_MODE);
  wire hit_ccctl = (paddr == `TCP_OFF_CCCTL);
  wire hit_edge = (paddr == `TCP_OFF_EDGE);
  wire hit_rega = (paddr == `TCP_OFF_REGA);
  wire hit_regb = (paddr == `TCP_OFF_REGB);
  wire hit_count = (paddr == `TCP_OFF_COUNT);
  wire hit_stat = (paddr == `TCP_OFF_STAT);
  wire mapped = hit_mode | hit_ccctl | hit_edge | hit_rega | hit_regb | hit_count | hit_stat;
  wire cfg_wr = wr & ~running;

  // Edge for a pin-A capture into reg A is the opposite of the valid edge
  wire [1:0] sel_a_inv = (edge_cfg.sel_a == `TCP_ES_RISE) ? `TCP_ES_FALL :
                         (edge_cfg.sel_a == `TCP_ES_FALL) ? `TCP_ES_RISE : `TCP_ES_BAD;
  wire valid_a = edge_hit(edge_cfg.sel_a, edges_a);
  wire trig_a_pin_a = edge_hit(sel_a_inv, edges_a);
  wire trig_a_pin_b = edge_hit(edge_cfg.sel_b, edges_b);
  wire cap_a = running & reg_a_capture_select & (reg_a_src_b ? trig_a_pin_b : trig_a_pin_a);
  wire cap_b = running & reg_b_capture_select & valid_a;
  wire wr_a = word_wr & hit_rega & ~running;
  wire wr_b = word_wr & hit_regb & (~running | ppg_mode);

  // Counter clear sources
  wire clr_edge = running & (op_mode == `TCP_OPM_EDGE) & valid_a;
  wire clr_match = running & (op_mode == `TCP_OPM_MATCH) & match_a & ~reg_a_capture_select;
  wire wrap = running & (up_counter == `TCP_CNT_MAX);

  // Registers A and B
  tcp_capcmp u_reg_a (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_a),
    .wr_data(pwdata[15:0]),
    .cap_en(cap_a),
    .count(up_counter),
    .value(capcmp_reg_a),
    .match(match_a)
  );
  tcp_capcmp u_reg_b (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_b),
    .wr_data(pwdata[15:0]),
    .cap_en(cap_b),
    .count(up_counter),
    .value(capcmp_reg_b),
    .match(match_b)
  );

  always_comb begin
    next_state = state;
    case (state)
      TCP_IDLE: if (op_mode != `TCP_OPM_STOP) next_state = TCP_RUN;
      TCP_RUN: if (op_mode == `TCP_OPM_STOP) next_state = TCP_IDLE;
      default: next_state = TCP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= TCP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_counter <= `TCP_CNT_ZERO;
    end else if (!running || clr_edge || clr_match) begin
      up_counter <= `TCP_CNT_ZERO;
    end else begin
      up_counter <= up_counter + `TCP_CNT_ONE;
    end
  end

  // Match flags fire once per counter value
  logic [15:0] last_cnt_a;
  logic [15:0] last_cnt_b;
  logic seen_a;
  logic seen_b;
  // match A; zero case follows counter
  wire fire_a = running & ~reg_a_capture_select & match_a &
                ~(seen_a & (last_cnt_a == up_counter));
  wire fire_b = running & ~reg_b_capture_select & match_b &
                ~(seen_b & (last_cnt_b == up_counter));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
      last_cnt_a <= `TCP_CNT_ZERO;
      last_cnt_b <= `TCP_CNT_ZERO;
      seen_a <= 1'b0;
      seen_b <= 1'b0;
    end else begin
      irq_a_q <= fire_a;
      irq_b_q <= fire_b;
      seen_a <= fire_a;
      seen_b <= fire_b;
      last_cnt_a <= fire_a ? up_counter : last_cnt_a;
      last_cnt_b <= fire_b ? up_counter : last_cnt_b;
    end
  end
  assign match_irq_a = irq_a_q;
  assign match_irq_b = irq_b_q;

  // byte/bit writable mode; overflow sticky, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_control <= `TCP_MODE_RST;
    end else begin
      if (wr && hit_mode && pstrb[0]) begin
        timer_mode_control[3:1] <= pwdata[3:1];
      end
      if (wrap) begin
        timer_mode_control[`TCP_MODE_OVF_BIT] <= 1'b1;
      end else if (wr && hit_mode && pstrb[0]) begin
        timer_mode_control[`TCP_MODE_OVF_BIT] <= pwdata[`TCP_MODE_OVF_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capcmp_control <= 4'h0;
      edge_cfg <= 4'h0;
    end else begin
      if (cfg_wr && hit_ccctl && pstrb[0]) begin
        capcmp_control <= pwdata[3:0];
      end
      if (cfg_wr && hit_edge && pstrb[0]) begin
        edge_cfg <= pwdata[3:0];
      end
    end
  end

  // read data registered, capture unaffected; word regs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= hit_mode ? {24'h0, timer_mode_control} :
                hit_ccctl ? {28'h0, capcmp_control} :
                hit_edge ? {28'h0, edge_cfg} :
                hit_rega ? {16'h0, capcmp_reg_a} :
                hit_regb ? {16'h0, capcmp_reg_b} :
                hit_count ? {16'h0, up_counter} :
                hit_stat ? {29'h0, ppg_mode, op_mode_hi | op_mode_lo, running} : 32'h0;
    end
  end

  // Zero wait states; unmapped or partial reg-pair writes error
  assign pready = 1'b1;
  assign pslverr = acc & (~mapped | ((hit_rega | hit_regb) & pwrite & (pstrb != 4'hF)) |
                          (hit_count & pwrite));

  // Assertions
  sequence s_run_step;
    running && !clr_edge && !clr_match;
  endsequence
  property p_count_step;
    @(posedge pclk) disable iff (!presetn) s_run_step |=> up_counter == $past(up_counter) + 16'h0001;
  endproperty
  a_counter_step: assert property (p_count_step) else $error("counter did not step");
  a_counter_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    wrap && !clr_edge && !clr_match |=> up_counter == 16'h0000) else $error("no wrap");
  a_stop_clears: assert property (@(posedge pclk) disable iff (!presetn)
    !running |=> up_counter == 16'h0000) else $error("stopped counter not zero");
  a_cap_b_load: assert property (@(posedge pclk) disable iff (!presetn)
    cap_b |=> capcmp_reg_b == $past(up_counter)) else $error("B capture wrong");
  a_cap_a_load: assert property (@(posedge pclk) disable iff (!presetn)
    cap_a |=> capcmp_reg_a == $past(up_counter)) else $error("A capture wrong");
  a_a_none_both: assert property (@(posedge pclk) disable iff (!presetn)
    edge_cfg.sel_a == 2'h3 && !reg_a_src_b |-> !cap_a) else $error("A captured on 11");
  a_a_held_run: assert property (@(posedge pclk) disable iff (!presetn)
    running && !cap_a ##1 running |-> $stable(capcmp_reg_a)) else $error("A changed");
  a_b_ppg_only: assert property (@(posedge pclk) disable iff (!presetn)
    running && !ppg_mode && !cap_b |=> $stable(capcmp_reg_b)) else $error("B changed");
  a_irq_b_cause: assert property (@(posedge pclk) disable iff (!presetn)
    match_irq_b |-> $past(match_b) && $past(running)) else $error("B irq no match");
  a_irq_a_cause: assert property (@(posedge pclk) disable iff (!presetn)
    match_irq_a |-> $past(match_a) && !$past(reg_a_capture_select)) else $error("A irq bad");

  // Compare hits seen from the register values, not the match nets
  sequence s_a_cmp_hit;
    running && !reg_a_capture_select && capcmp_reg_a == up_counter;
  endsequence
  sequence s_b_cmp_hit;
    running && !reg_b_capture_select && capcmp_reg_b == up_counter;
  endsequence
  a_a_cmp_fire: assert property (@(posedge pclk) disable iff (!presetn)
    s_a_cmp_hit |=> match_irq_a) else $error("A match missed");
  a_b_cmp_fire: assert property (@(posedge pclk) disable iff (!presetn)
    s_b_cmp_hit |=> match_irq_b) else $error("B match missed");
  a_a_zero_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    running && !reg_a_capture_select && capcmp_reg_a == 16'h0000 && up_counter == 16'h0000
    |=> match_irq_a) else $error("A zero match missed");
  a_b_zero_clr: assert property (@(posedge pclk) disable iff (!presetn)
    running && !reg_b_capture_select && capcmp_reg_b == 16'h0000 && up_counter == 16'h0000
    |=> match_irq_b) else $error("B zero match missed");
  a_irq_a_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    match_irq_a |=> !match_irq_a) else $error("A pulse too long");
  a_irq_b_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    match_irq_b |=> !match_irq_b) else $error("B pulse too long");
  a_ovf_set: assert property (@(posedge pclk) disable iff (!presetn)
    wrap |=> timer_mode_control[`TCP_MODE_OVF_BIT]) else $error("overflow not flagged");
  a_edge_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clr_edge |=> up_counter == 16'h0000) else $error("edge clear missed");
  a_match_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clr_match |=> up_counter == 16'h0000) else $error("match clear missed");
  a_a_stop_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_a && !cap_a |=> capcmp_reg_a == $past(pwdata[15:0])) else $error("A write lost");
  a_b_ppg_write: assert property (@(posedge pclk) disable iff (!presetn)
    running && ppg_mode && wr_b && !cap_b |=> capcmp_reg_b == $past(pwdata[15:0]))
    else $error("B write lost");
  a_cfg_locked: assert property (@(posedge pclk) disable iff (!presetn)
    running |=> $stable(capcmp_control)) else $error("control changed while running");
  a_edge_locked: assert property (@(posedge pclk) disable iff (!presetn)
    running |=> $stable(edge_cfg)) else $error("edge select changed while running");
  a_count_ro: assert property (@(posedge pclk) disable iff (!presetn)
    hit_count && wr |-> pslverr) else $error("counter write accepted");
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the timer capture/compare pair
`default_nettype none
`include "tcp_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic pin_a = 1'b0;
  logic pin_b = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_a;
  logic irq_b;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int na = 0;
  int nb = 0;
  int k;
  int m;

  tcp_top tcp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_pin_a(pin_a), .trigger_pin_b(pin_b),
    .match_irq_a(irq_a), .match_irq_b(irq_b));

  // Clock source, 20 ns period
  always #10 pclk = ~pclk;

  // Cycle count, match pulse counts and hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    na <= na + (irq_a === 1'b1 ? 1 : 0);
    nb <= nb + (irq_b === 1'b1 ? 1 : 0);
    if (cyc == 90000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  // Compare seen against expected and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // no wait access
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Capture trial: rising then falling pin edge, capture expected per edge
  task automatic cap(input logic [3:0] cc, input logic [3:0] es, input logic [11:0] ro,
      input logic onb, input logic er, input logic ef);
    logic [31:0] old;
    logic [31:0] c1;
    logic ok;
    wr(`TCP_OFF_MODE, 32'h0);
    wr(`TCP_OFF_CCCTL, {28'h0, cc});
    wr(`TCP_OFF_EDGE, {28'h0, es});
    wr(ro, 32'h0);
    wr(`TCP_OFF_MODE, 32'h4);
    for (int e = 0; e < 2; e++) begin
      wt(20);
      apb(1'b0, ro, 32'h0);
      old = rd;
      apb(1'b0, `TCP_OFF_COUNT, 32'h0);
      c1 = rd;
      if (onb) pin_b <= ~pin_b;
      else pin_a <= ~pin_a;
      wt(8);
      apb(1'b0, ro, 32'h0);
      ok = ((e == 0) ? er : ef) ? ((rd - c1) inside {[1:20]}) : (rd === old);
      check({31'h0, ok}, 32'h1);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, read-only counter, unmapped place, partial write
    rdc(`TCP_OFF_MODE, 32'h0);
    rdc(`TCP_OFF_REGB, 32'h0);
    rdc(`TCP_OFF_REGA, 32'h0);
    rdc(`TCP_OFF_COUNT, 32'h0);
    wr(`TCP_OFF_COUNT, 32'h5);
    check(err, 32'h1);
    apb(1'b0, 12'h01C, 32'h0);
    check(err, 32'h1);
    pstrb <= 4'h3;
    wr(`TCP_OFF_REGB, 32'h7);
    check(err, 32'h1);
    pstrb <= 4'hF;
    rdc(`TCP_OFF_REGB, 32'h0);
    // Compare matches on both registers while free running
    wr(`TCP_OFF_REGA, 32'h10);
    wr(`TCP_OFF_REGB, 32'h20);
    k = na;
    m = nb;
    wr(`TCP_OFF_MODE, 32'h4);
    wt(12);
    check(na - k, 32'h0);
    wt(12);
    check(na - k, 32'h1);
    check(nb - m, 32'h0);
    wt(16);
    check(nb - m, 32'h1);
    rdc(`TCP_OFF_STAT, 32'h3);
    // Reg A and B writes while running are dropped, except reg B in pulse-pattern mode
    wr(`TCP_OFF_REGA, 32'h55);
    wr(`TCP_OFF_REGB, 32'h66);
    rdc(`TCP_OFF_REGA, 32'h10);
    rdc(`TCP_OFF_REGB, 32'h20);
    wr(`TCP_OFF_MODE, 32'h0);
    rdc(`TCP_OFF_COUNT, 32'h0);
    rdc(`TCP_OFF_STAT, 32'h0);
    wr(`TCP_OFF_CCCTL, 32'h8);
    wr(`TCP_OFF_MODE, 32'h4);
    wr(`TCP_OFF_REGB, 32'h1234);
    rdc(`TCP_OFF_REGB, 32'h1234);
    // Every valid edge select code (00, 01, 11) on every capture path
    // codes avoid 10
    cap(4'h4, 4'h0, `TCP_OFF_REGB, 1'b0, 1'b0, 1'b1);
    cap(4'h4, 4'h1, `TCP_OFF_REGB, 1'b0, 1'b1, 1'b0);
    cap(4'h4, 4'h3, `TCP_OFF_REGB, 1'b0, 1'b1, 1'b1);
    cap(4'h1, 4'h1, `TCP_OFF_REGA, 1'b0, 1'b0, 1'b1);
    cap(4'h1, 4'h0, `TCP_OFF_REGA, 1'b0, 1'b1, 1'b0);
    cap(4'h1, 4'h3, `TCP_OFF_REGA, 1'b0, 1'b0, 1'b0);
    cap(4'h3, 4'h0, `TCP_OFF_REGA, 1'b1, 1'b0, 1'b1);
    cap(4'h3, 4'h4, `TCP_OFF_REGA, 1'b1, 1'b1, 1'b0);
    cap(4'h3, 4'hC, `TCP_OFF_REGA, 1'b1, 1'b1, 1'b1);
    // Clear-on-match and clear-on-edge modes
    wr(`TCP_OFF_MODE, 32'h0);
    wr(`TCP_OFF_CCCTL, 32'h0);
    wr(`TCP_OFF_REGA, 32'h8);
    wr(`TCP_OFF_REGB, 32'h0);
    k = na;
    m = nb;
    wr(`TCP_OFF_MODE, 32'hC);
    wt(40);
    check({31'h0, (na - k) inside {[3:4]}}, 32'h1);
    check({31'h0, (nb - m) inside {[4:5]}}, 32'h1);
    apb(1'b0, `TCP_OFF_COUNT, 32'h0);
    check({31'h0, rd <= 32'h8}, 32'h1);
    wr(`TCP_OFF_MODE, 32'h0);
    wr(`TCP_OFF_EDGE, 32'h1);
    wr(`TCP_OFF_MODE, 32'h8);
    wt(50);
    pin_a <= 1'b1;
    wt(4);
    apb(1'b0, `TCP_OFF_COUNT, 32'h0);
    check({31'h0, rd < 32'h8}, 32'h1);
    pin_a <= 1'b0;
    // Zero compare values fire after the counter wraps
    wr(`TCP_OFF_MODE, 32'h0);
    wr(`TCP_OFF_CCCTL, 32'h0);
    wr(`TCP_OFF_REGA, 32'h0);
    wr(`TCP_OFF_REGB, 32'h0);
    wr(`TCP_OFF_MODE, 32'h4);
    wt(100);
    k = na;
    m = nb;
    for (int i = 0; i < 66000 && na == k; i++) @(posedge pclk);
    apb(1'b0, `TCP_OFF_COUNT, 32'h0);
    check({31'h0, rd < 32'h10}, 32'h1);
    check(na - k, 32'h1);
    check(nb - m, 32'h1);
    rdc(`TCP_OFF_MODE, 32'h5);
    end_sim();
  end
endmodule
`default_nettype wire
